/* File: shared/eew_pkg.sv */
// constants, types and byte-sequence decoding for the eeprom write-side host controller
// assumes one 10 MHz clock; the eeprom sits on plain parallel pins beside this controller
package eew_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and widths
	localparam int CLK_PERIOD_NS = 100;  // 10 MHz system clock
	localparam int ADDR_W        = 17;   // byte address of one 128k die
	localparam int DATA_W        = 8;    // byte-wide data pins
	localparam int TIMER_W       = 18;   // wide enough for the write cycle count
	localparam int PHASE_W       = 3;    // bus cycle phase counter
	localparam int PAGE_BYTES    = 128;  // bytes in one page
	localparam int PAGE_LSB      = 7;    // low address bits select the byte in a page

	////////////////////////////////////////////////////////////////////////////////
	// times as printed, then cycle counts (all round up except the load window, which rounds down)
	localparam int T_PULSE_NS       = 250;  // strobe low width we give every write
	localparam int T_GLITCH_NS      = 20;   // pulses this short are rejected as noise
	localparam int T_ACC_NS         = 250;  // read access we allow before sampling
	localparam int T_LOAD_WINDOW_US = 30;   // longest gap between page bytes
	localparam int T_AUTO_START_US  = 100;  // idle strobes before programming starts
	localparam int T_RECOVER_US     = 100;  // protect-reset high before first write
	localparam int T_GUARD_MS       = 10;   // protect-reset high after last byte
	localparam int T_WRITE_CYCLE_MS = 15;   // longest internal write cycle

	localparam int PULSE_CYC   = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GLITCH_CYC  = (T_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC     = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WINDOW_CYC  = (T_LOAD_WINDOW_US * 1000) / CLK_PERIOD_NS;
	localparam int STROBE_LAST = PULSE_CYC + 2;                 // last phase of a write
	localparam int WINDOW_WAIT = WINDOW_CYC - STROBE_LAST - 2;  // leaves room for next strobe
	localparam int AUTO_CYC    = (T_AUTO_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (T_RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GUARD_CYC   = (T_GUARD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC   = (T_WRITE_CYCLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// software protection command bytes
	localparam logic [ADDR_W-1:0] SEQ_ADDR_A  = 17'h0_5555;  // first command address
	localparam logic [ADDR_W-1:0] SEQ_ADDR_B  = 17'h0_2AAA;  // second command address
	localparam logic [DATA_W-1:0] SEQ_KEY_1   = 8'hAA;
	localparam logic [DATA_W-1:0] SEQ_KEY_2   = 8'h55;
	localparam logic [DATA_W-1:0] SEQ_ERASE   = 8'h80;       // third byte of cancel
	localparam logic [DATA_W-1:0] SEQ_CANCEL  = 8'h20;       // last byte of cancel
	localparam logic [DATA_W-1:0] SEQ_LOCK    = 8'hA0;       // third byte of lock
	localparam int                LOCK_LEN    = 3;
	localparam int                UNLOCK_LEN  = 6;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		OP_WRITE  = 2'b00,  // load one byte, page continues while compatible
		OP_READ   = 2'b01,  // one plain read
		OP_LOCK   = 2'b10,  // three-byte prefix alone
		OP_UNLOCK = 2'b11   // six-byte cancel
	} eew_op_e;

	typedef enum logic [2:0] {
		ST_PROTECT = 3'b000,  // protect-reset held low
		ST_WAKE    = 3'b001,  // recovery after raising protect-reset
		ST_IDLE    = 3'b010,
		ST_STROBE  = 3'b011,  // one write bus cycle
		ST_WINDOW  = 3'b100,  // page load window open
		ST_SETTLE  = 3'b101,  // strobes idle until auto program
		ST_POLL    = 3'b110,  // polling reads until done
		ST_READ    = 3'b111   // one user read
	} eew_state_e;

	// command sequence address by position
	function automatic logic [ADDR_W-1:0] seqAddr(input logic [PHASE_W-1:0] idx);
		seqAddr = (idx == 3'd1 || idx == 3'd4) ? SEQ_ADDR_B : SEQ_ADDR_A;
	endfunction : seqAddr

	// command sequence data by operation and position
	function automatic logic [DATA_W-1:0] seqData(input eew_op_e op, input logic [PHASE_W-1:0] idx);
		unique case (idx)
			3'd0, 3'd3: seqData = SEQ_KEY_1;
			3'd1, 3'd4: seqData = SEQ_KEY_2;
			3'd2:       seqData = (op == OP_UNLOCK) ? SEQ_ERASE : SEQ_LOCK;
			default:    seqData = SEQ_CANCEL;
		endcase
	endfunction : seqData

endpackage : eew_pkg

/* File: shared/eew_timer_if.sv */
// load and expiry signals between the host controller and its countdown timers
// assumes both ends share the controller clock
`timescale 1ns/1ps
interface eew_timer_if;
	import eew_pkg::*;
	logic               load;       // one-cycle load request
	logic [TIMER_W-1:0] loadValue;  // cycles until expiry
	logic               expired;    // level, high once the count has run out
	modport timer (input load, input loadValue, output expired);
	modport user (output load, output loadValue, input expired);
endinterface : eew_timer_if

/* File: design/eew_timer.sv */
// countdown timer: expires the given number of cycles after a load
// assumes synchronous active-high reset; reads as expired out of reset
`timescale 1ns/1ps
module eew_timer (
	input wire logic     clock,
	input wire logic     rst,
	eew_timer_if.timer   tif
);
	import eew_pkg::*;

	logic [TIMER_W-1:0] count_reg;    // cycles still to run
	logic [TIMER_W-1:0] count_next;
	logic               expired_reg;  // run out, held until next load
	logic               expired_next;

	// load wins over counting so a reload never loses a cycle
	always_comb begin
		count_next   = count_reg;
		expired_next = expired_reg;
		if (tif.load) begin
			count_next   = tif.loadValue;
			expired_next = 1'b0;
		end else if (count_reg > 1) begin
			count_next = count_reg - 1'b1;
		end else begin
			count_next   = '0;
			expired_next = 1'b1;
		end
	end

	// state registers
	always_ff @(posedge clock) begin
		if (rst) begin
			count_reg   <= '0;
			expired_reg <= 1'b1;
		end else begin
			count_reg   <= count_next;
			expired_reg <= expired_next;
		end
	end

	assign tif.expired = expired_reg;
endmodule : eew_timer

/* File: design/eew_host_ctrl.sv */
// host-side controller that drives a byte-wide eeprom through its pins
// assumes memReadyBusy is pulled up outside and all pin inputs are synchronous to clock
`timescale 1ns/1ps
module eew_host_ctrl #(
	parameter int GUARD_CYCLES = eew_pkg::GUARD_CYC,  // protect-reset hold after last byte
	parameter int WRITE_CYCLES = eew_pkg::WRITE_CYC   // polling gives up after this
) (
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         powerGood,      // low while supply ramps
	input  wire logic                         softProtect,    // prefix every page
	input  wire logic                         cmdValid,
	input  wire eew_pkg::eew_op_e             cmdOp,
	input  wire logic [eew_pkg::ADDR_W-1:0]   cmdAddr,
	input  wire logic [eew_pkg::DATA_W-1:0]   cmdData,
	input  wire logic                         cmdLast,        // closes the page
	output logic                              cmdAck,
	output logic                              rspValid,
	output logic [eew_pkg::DATA_W-1:0]        rspData,
	output logic                              rspError,
	output logic                              busy,
	output logic [eew_pkg::ADDR_W-1:0]        memAddr,
	input  wire logic [eew_pkg::DATA_W-1:0]   memDqIn,
	output logic [eew_pkg::DATA_W-1:0]        memDqOut,
	output logic                              memDqOeN,
	output logic                              memCeN,
	output logic                              memOeN,
	output logic                              memWeN,
	input  wire logic                         memReadyBusy,   // high when released
	output logic                              protectResetN
);
	import eew_pkg::*;

	if (GUARD_CYCLES < 1 || GUARD_CYCLES >= 2 ** TIMER_W) $error("GUARD_CYCLES out of range");
	if (WRITE_CYCLES < 1 || WRITE_CYCLES >= 2 ** TIMER_W) $error("WRITE_CYCLES out of range");
	if (STROBE_LAST >= 2 ** PHASE_W) $error("phase counter too narrow");

	////////////////////////////////////////////////////////////////////////////////
	// timers: main for waits in the sequence, guard for the hold after the last byte
	eew_timer_if mainIf ();
	eew_timer_if guardIf ();
	eew_timer mainTimer (.clock(clock), .rst(rst), .tif(mainIf));
	eew_timer guardTimer (.clock(clock), .rst(rst), .tif(guardIf));

	////////////////////////////////////////////////////////////////////////////////
	// sequencing state
	eew_state_e                 state_reg, state_next;
	logic [PHASE_W-1:0]         phase_reg, phase_next;        // phase within a bus cycle
	eew_op_e                    op_reg, op_next;              // operation in progress
	logic [PHASE_W-1:0]         seqIdx_reg, seqIdx_next;      // command byte position
	logic [PHASE_W-1:0]         seqLen_reg, seqLen_next;      // command bytes to send
	logic                       userPend_reg, userPend_next;  // user byte still to send
	logic                       userByte_reg, userByte_next;  // current strobe carries user data
	logic                       hasData_reg, hasData_next;    // page loaded real data
	logic                       last_reg, last_next;          // page closed by the user
	logic [ADDR_W-1:0]          uAddr_reg, uAddr_next;        // held user address
	logic [DATA_W-1:0]          uData_reg, uData_next;        // held user data
	logic [ADDR_W-PAGE_LSB-1:0] page_reg, page_next;          // upper bits of open page
	logic [PAGE_LSB:0]          pageCnt_reg, pageCnt_next;    // bytes loaded in page
	logic [DATA_W-1:0]          lastData_reg, lastData_next;  // last byte loaded
	logic [ADDR_W-1:0]          addr_next;
	logic [DATA_W-1:0]          dq_next, rspData_next;
	logic ack_next, rspValid_next, rspError_next, busy_next, prot_next;
	logic ceN_next, oeN_next, weN_next, dqOeN_next;
	logic inFlight;  // programming may be under way

	assign inFlight = state_reg inside {ST_STROBE, ST_WINDOW, ST_SETTLE, ST_POLL};

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		state_next = state_reg;  phase_next = phase_reg;  op_next = op_reg;
		seqIdx_next = seqIdx_reg;  seqLen_next = seqLen_reg;  userPend_next = userPend_reg;
		userByte_next = userByte_reg;  hasData_next = hasData_reg;  last_next = last_reg;
		uAddr_next = uAddr_reg;  uData_next = uData_reg;  page_next = page_reg;
		pageCnt_next = pageCnt_reg;  lastData_next = lastData_reg;
		addr_next = memAddr;  dq_next = memDqOut;  rspData_next = rspData;
		ack_next = 1'b0;  rspValid_next = 1'b0;  rspError_next = 1'b0;
		prot_next = protectResetN;
		mainIf.load = 1'b0;  mainIf.loadValue = '0;
		guardIf.load = 1'b0;  guardIf.loadValue = TIMER_W'(GUARD_CYCLES);
		unique case (state_reg)
			ST_PROTECT: if (powerGood) begin
				prot_next = 1'b1;
				mainIf.load = 1'b1;
				mainIf.loadValue = TIMER_W'(RECOVER_CYC);
				state_next = ST_WAKE;
			end
			ST_WAKE: if (mainIf.expired) state_next = ST_IDLE;
			ST_IDLE: begin
				if (!powerGood && guardIf.expired) begin
					prot_next = 1'b0;
					state_next = ST_PROTECT;
				end else if (cmdValid && powerGood) begin
					ack_next = 1'b1;
					op_next = cmdOp;  uAddr_next = cmdAddr;  uData_next = cmdData;
					last_next = cmdLast;  seqIdx_next = '0;  phase_next = '0;
					hasData_next = 1'b0;  pageCnt_next = '0;
					page_next = cmdAddr[ADDR_W-1:PAGE_LSB];
					addr_next = seqAddr('0);
					dq_next = seqData(cmdOp, '0);
					userByte_next = 1'b0;
					state_next = ST_STROBE;
					unique case (cmdOp)
						OP_WRITE: begin
							userPend_next = softProtect;
							seqLen_next = softProtect ? PHASE_W'(LOCK_LEN) : '0;
							if (!softProtect) begin
								addr_next = cmdAddr;  dq_next = cmdData;  userByte_next = 1'b1;
							end
						end
						OP_READ: begin
							addr_next = cmdAddr;
							state_next = ST_READ;
						end
						OP_LOCK: begin
							userPend_next = 1'b0;
							seqLen_next = PHASE_W'(LOCK_LEN);
						end
						OP_UNLOCK: begin
							userPend_next = 1'b0;
							seqLen_next = PHASE_W'(UNLOCK_LEN);
						end
					endcase
				end
			end
			ST_STROBE: begin
				phase_next = phase_reg + 1'b1;
				if (phase_reg == PHASE_W'(STROBE_LAST)) begin
					phase_next = '0;
					if (userByte_reg) begin
						hasData_next = 1'b1;
						lastData_next = memDqOut;
						pageCnt_next = pageCnt_reg + 1'b1;
						guardIf.load = 1'b1;
					end
					if (seqIdx_reg + 1'b1 < seqLen_reg) begin
						seqIdx_next = seqIdx_reg + 1'b1;
						addr_next = seqAddr(seqIdx_next);
						dq_next = seqData(op_reg, seqIdx_next);
					end else if (userPend_reg) begin
						userPend_next = 1'b0;  userByte_next = 1'b1;
						addr_next = uAddr_reg;  dq_next = uData_reg;
					end else if (op_reg == OP_WRITE && !last_reg &&
							pageCnt_next < (PAGE_LSB + 1)'(PAGE_BYTES)) begin
						mainIf.load = 1'b1;
						mainIf.loadValue = TIMER_W'(WINDOW_WAIT);
						state_next = ST_WINDOW;
					end else begin
						mainIf.load = 1'b1;
						mainIf.loadValue = TIMER_W'(AUTO_CYC);
						state_next = ST_SETTLE;
					end
				end
			end
			ST_WINDOW: begin
				if (cmdValid && cmdOp == OP_WRITE && !mainIf.expired &&
						cmdAddr[ADDR_W-1:PAGE_LSB] == page_reg) begin
					ack_next = 1'b1;
					addr_next = cmdAddr;  dq_next = cmdData;  last_next = cmdLast;
					userByte_next = 1'b1;  phase_next = '0;
					state_next = ST_STROBE;
				end else if (cmdValid || mainIf.expired) begin
					mainIf.load = 1'b1;
					mainIf.loadValue = TIMER_W'(AUTO_CYC);
					state_next = ST_SETTLE;
				end
			end
			ST_SETTLE: if (mainIf.expired) begin
				phase_next = '0;
				state_next = hasData_reg ? ST_POLL : ST_IDLE;
				mainIf.load = hasData_reg;
				mainIf.loadValue = TIMER_W'(WRITE_CYCLES);
			end
			ST_POLL: begin
				phase_next = (phase_reg == PHASE_W'(ACC_CYC + 1)) ? '0 : phase_reg + 1'b1;
				if (phase_reg == PHASE_W'(ACC_CYC)) begin
					if (memDqIn[DATA_W-1] == lastData_reg[DATA_W-1] && memReadyBusy) begin
						rspValid_next = 1'b1;
						rspData_next = memDqIn;
						state_next = ST_IDLE;
					end else if (mainIf.expired) begin
						rspValid_next = 1'b1;
						rspError_next = 1'b1;
						rspData_next = memDqIn;
						state_next = ST_IDLE;
					end
				end
			end
			ST_READ: begin
				phase_next = phase_reg + 1'b1;
				if (phase_reg == PHASE_W'(ACC_CYC)) begin
					rspValid_next = 1'b1;
					rspData_next = memDqIn;
				end else if (phase_reg == PHASE_W'(ACC_CYC + 1)) begin
					state_next = ST_IDLE;
				end
			end
		endcase
		// supply failing mid-operation: protect at once and report the lost write
		if (!powerGood && state_reg != ST_PROTECT && state_reg != ST_IDLE) begin
			prot_next = 1'b0;
			rspValid_next = inFlight;
			rspError_next = inFlight;
			state_next = ST_PROTECT;
		end
		busy_next = state_next != ST_IDLE;
	end

	// pin levels follow the next state and phase so every pin leaves a flip-flop
	always_comb begin
		ceN_next = 1'b1;  oeN_next = 1'b1;  weN_next = 1'b1;  dqOeN_next = 1'b1;
		if (state_next == ST_STROBE && phase_next <= PHASE_W'(PULSE_CYC + 1)) begin
			ceN_next = 1'b0;
			dqOeN_next = 1'b0;
			weN_next = !(phase_next >= 1 && phase_next <= PHASE_W'(PULSE_CYC));
		end else if ((state_next == ST_POLL || state_next == ST_READ) &&
				phase_next <= PHASE_W'(ACC_CYC)) begin
			ceN_next = 1'b0;
			oeN_next = 1'b0;
		end
		if (!prot_next) begin
			ceN_next = 1'b1;
			oeN_next = 1'b1;  weN_next = 1'b1;  dqOeN_next = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= ST_PROTECT;  phase_reg <= '0;  op_reg <= OP_WRITE;
			seqIdx_reg <= '0;  seqLen_reg <= '0;  userPend_reg <= 1'b0;  userByte_reg <= 1'b0;
			hasData_reg <= 1'b0;  last_reg <= 1'b0;  uAddr_reg <= '0;  uData_reg <= '0;
			page_reg <= '0;  pageCnt_reg <= '0;  lastData_reg <= '0;
			memAddr <= '0;  memDqOut <= '0;  rspData <= '0;
			cmdAck <= 1'b0;  rspValid <= 1'b0;  rspError <= 1'b0;  busy <= 1'b1;
			protectResetN <= 1'b0;
			memCeN <= 1'b1;  memOeN <= 1'b1;  memWeN <= 1'b1;  memDqOeN <= 1'b1;
		end else begin
			state_reg <= state_next;  phase_reg <= phase_next;  op_reg <= op_next;
			seqIdx_reg <= seqIdx_next;  seqLen_reg <= seqLen_next;
			userPend_reg <= userPend_next;  userByte_reg <= userByte_next;
			hasData_reg <= hasData_next;  last_reg <= last_next;
			uAddr_reg <= uAddr_next;  uData_reg <= uData_next;
			page_reg <= page_next;  pageCnt_reg <= pageCnt_next;  lastData_reg <= lastData_next;
			memAddr <= addr_next;  memDqOut <= dq_next;  rspData <= rspData_next;
			cmdAck <= ack_next;  rspValid <= rspValid_next;  rspError <= rspError_next;
			busy <= busy_next;  protectResetN <= prot_next;
			memCeN <= ceN_next;  memOeN <= oeN_next;  memWeN <= weN_next;  memDqOeN <= dqOeN_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	logic [9:0] gapCnt;  // cycles since the last strobe rose while a page is open
	always_ff @(posedge clock) begin
		if (rst || state_reg == ST_STROBE || state_reg == ST_IDLE) gapCnt <= '0;
		else if (state_reg == ST_WINDOW) gapCnt <= gapCnt + 1'b1;
	end

	a_protect_during_access: assert property (!memCeN |-> protectResetN)
		else $error("access with protect-reset low");
	a_no_access_off: assert property (!protectResetN |-> memCeN && memWeN && memOeN)
		else $error("pins active while protected");
	a_power_drop_protect: assert property (!powerGood && inFlight
		|=> !protectResetN) else $error("supply drop left protect-reset high");
	a_guard_hold_time: assert property ($fell(protectResetN) && $past(state_reg) == ST_IDLE
		|-> $past(guardIf.expired)) else $error("protect-reset dropped inside hold time");
	a_strobe_pulse_width: assert property ($fell(memWeN) |-> !memWeN[*3] ##1 memWeN)
		else $error("write strobe width wrong");
	a_strobe_stable_pins: assert property (!memWeN |=> $stable(memAddr) && $stable(memDqOut)
		&& !memDqOeN && !memCeN) else $error("address or data moved under strobe");
	a_prefix_bytes: assert property ($fell(memWeN) && !userByte_reg
		|-> memDqOut == seqData(op_reg, seqIdx_reg)) else $error("wrong command byte");
	a_page_upper_bits: assert property ($fell(memWeN) && userByte_reg && op_reg == OP_WRITE
		|-> memAddr[ADDR_W-1:PAGE_LSB] == page_reg) else $error("byte outside open page");
	a_load_window: assert property (state_reg == ST_WINDOW |-> gapCnt < 10'(WINDOW_CYC - STROBE_LAST))
		else $error("page byte gap too long");
	a_settle_idle: assert property ($rose(state_reg == ST_SETTLE) |-> (memWeN && memCeN) [*8])
		else $error("strobes active before auto program");

	c_protected_write: cover property (softProtect && $fell(memWeN) && userByte_reg);
	c_unlock_done: cover property (op_reg == OP_UNLOCK && state_reg == ST_SETTLE);
	c_poll_done: cover property (rspValid && !rspError && state_reg == ST_IDLE);
	c_page_two_bytes: cover property (state_reg == ST_WINDOW && cmdAck);
endmodule : eew_host_ctrl

/* File: test/eew_eeprom_model.sv */
// eeprom behaviour at its pins, partner of the host controller
// assumes pins are sampled on the controller clock; ready/busy has a pull-up outside
`timescale 1ns/1ps
module eew_eeprom_model #(parameter int IDLE_CYC = 1000, parameter int PROG_CYC = 50) (
	input  wire logic        clock,
	input  wire logic [16:0] memAddr,
	input  wire logic [7:0]  memDqOut,
	input  wire logic        memCeN,
	input  wire logic        memOeN,
	input  wire logic        memWeN,
	input  wire logic        protectResetN,
	output logic [7:0]       memDqIn,
	output logic             rdyLow
);
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]  mem [0:131071] = '{default: 8'hFF};  // erased array
	logic [16:0] qa [$], aReg;                         // loaded addresses
	logic [7:0]  qd [$], lastData, noise = 8'h00;      // loaded data
	logic        locked = 1'b0, wasStrobe = 1'b0;
	int          idle = 0, prog = 0;
	realtime     fallT;
	wire strobe = !memCeN && !memWeN;
	wire readOn = !memCeN && !memOeN && memWeN && protectResetN;
	initial rdyLow = 1'b0;
	// released pins show a pattern that changes every cycle, never the last value
	assign memDqIn = !readOn ? noise : rdyLow ? {~lastData[7], noise[6:0]} : mem[memAddr];
	// commit or spoil the loaded bytes; command prefixes are never stored
	task automatic commit(input bit good);
		int s;
		s = 0;
		if (qd.size() > 5 && {qd[0], qd[1], qd[2], qd[3], qd[4], qd[5]} == 48'hAA55_80AA_5520) begin
			locked = 1'b0;
			s = 6;
		end else if (qd.size() > 2 && {qd[0], qd[1], qd[2]} == 24'hAA_55A0) begin
			locked = 1'b1;
			s = 3;
		end else if (locked) s = qd.size();
		for (int i = s; i < qd.size(); i++) mem[qa[i]] = good ? qd[i] : ~qd[i];
		qa.delete();
		qd.delete();
	endtask : commit
	// strobe edges, load window, auto start and write cycle
	always @(posedge clock) begin
		wasStrobe <= strobe;
		noise <= noise + 8'h3B;
		if (strobe && !wasStrobe) begin
			aReg <= memAddr;
			fallT <= $realtime;
		end
		if (!strobe && wasStrobe && protectResetN && $realtime - fallT > 20.0 && prog == 0) begin
			qa.push_back(aReg);
			qd.push_back(memDqOut);
			lastData <= memDqOut;
			rdyLow <= 1'b1;
			idle <= 0;
		end else if (memCeN && memWeN && qa.size() > 0 && prog == 0) idle <= idle + 1;
		if (qa.size() > 0 && !protectResetN) begin
			commit(1'b0);
			prog <= 0;
			idle <= 0;
			rdyLow <= 1'b0;
		end else if (prog == 1) begin
			commit(1'b1);
			prog <= 0;
			rdyLow <= 1'b0;
		end else if (prog > 0) prog <= prog - 1;
		else if (idle == IDLE_CYC) begin
			prog <= PROG_CYC;
			idle <= 0;
		end
	end
endmodule : eew_eeprom_model

/* File: test/eew_host_ctrl_test.sv */
// self-checking bench: host controller driving the eeprom model
// assumes package, interface, design and model files compile first
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; $display("BAD %0t got %h want %h", $time, got, exp); end end
module eew_host_ctrl_test;
	import eew_pkg::*;
	logic        clock = 0, rst = 1, powerGood = 1, softProtect = 0, cmdValid = 0, cmdLast = 0;
	eew_op_e     cmdOp = OP_WRITE;
	logic [16:0] cmdAddr = '0, memAddr, a;
	logic [7:0]  cmdData = '0, rspData, memDqIn, memDqOut, d;
	logic        cmdAck, rspValid, rspError, busy, memDqOeN, memCeN, memOeN, memWeN, protectResetN, rdyLow;
	logic [9:0]  pending [$], note;  // {check data, error, data}
	int          checks = 0, fail_count = 0, cyc = 0;
	wire         memReadyBusy = !rdyLow;  // open drain with pull-up
	always #50 clock = ~clock;
	eew_host_ctrl #(.GUARD_CYCLES(200), .WRITE_CYCLES(400)) u_eew_host_ctrl (.clock, .rst, .powerGood, .softProtect,
		.cmdValid, .cmdOp, .cmdAddr, .cmdData, .cmdLast, .cmdAck, .rspValid, .rspData, .rspError, .busy, .memAddr,
		.memDqIn, .memDqOut, .memDqOeN, .memCeN, .memOeN, .memWeN, .memReadyBusy, .protectResetN);
	eew_eeprom_model u_eew_eeprom_model (.clock, .memAddr, .memDqOut, .memCeN, .memOeN, .memWeN, .protectResetN,
		.memDqIn, .rdyLow);
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// hold the request until acknowledged, note the answer it should bring
	task automatic issue(input eew_op_e op, input logic [16:0] ad, input logic [7:0] dt, input bit last, input bit want,
		input logic [9:0] exp);
		cmdOp <= op;
		cmdAddr <= ad;
		cmdData <= dt;
		cmdLast <= last;
		cmdValid <= 1'b1;
		if (want) pending.push_back(exp);
		do @(posedge clock); while (cmdAck !== 1'b1);
		cmdValid <= 1'b0;
		@(posedge clock);
	endtask : issue
	// each answer is matched against the oldest note
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			final_report();
		end
		// data pins must be driven for the whole strobe
		if (memWeN === 1'b0) `CHK(memDqOeN, 1'b0)
		if (rspValid === 1'b1) begin
			`CHK(pending.size() != 0, 1'b1)
			if (pending.size() != 0) begin
				note = pending.pop_front();
				`CHK(rspError, note[8])
				if (note[9]) `CHK(rspData, note[7:0])
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(85));
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		a = 17'($urandom);
		d = 8'($urandom);
		issue(OP_WRITE, a, d, 1, 1, {2'b10, d});
		issue(OP_READ, a, 8'h00, 0, 1, {2'b10, d});
		// page at both ends and the middle of its byte offsets
		for (int i = 0; i < 3; i++) issue(OP_WRITE, {a[16:7], 7'(i * 63 + i / 2)}, d + 8'(i), i == 2, i == 2,
			{2'b10, d + 8'(i)});
		for (int i = 0; i < 3; i++) issue(OP_READ, {a[16:7], 7'(i * 63 + i / 2)}, 8'h00, 0, 1, {2'b10, d + 8'(i)});
		// lock, then an unprefixed write must not land and polling gives up
		issue(OP_LOCK, 17'h0_0000, 8'h00, 0, 0, 10'h000);
		repeat (1100) @(posedge clock);  // idle auto start plus write cycle
		a = a ^ 17'h1_0000;
		d = {1'b0, 7'($urandom)};
		issue(OP_WRITE, a, d, 1, 1, 10'h100);
		softProtect <= 1'b1;
		issue(OP_WRITE, a, d, 1, 1, {2'b10, d});
		issue(OP_READ, a, 8'h00, 0, 1, {2'b10, d});
		softProtect <= 1'b0;
		issue(OP_UNLOCK, 17'h0_0000, 8'h00, 0, 0, 10'h000);
		repeat (1100) @(posedge clock);
		issue(OP_WRITE, a, ~d, 1, 1, {2'b10, ~d});
		issue(OP_READ, a, 8'h00, 0, 1, {2'b10, ~d});
		issue(OP_READ, SEQ_ADDR_A, 8'h00, 0, 1, 10'h2FF);
		// supply drop while the byte waits for programming
		issue(OP_WRITE, a, d + 8'h01, 1, 1, 10'h100);
		repeat (20) @(posedge clock);
		powerGood <= 1'b0;
		repeat (3) @(posedge clock);
		`CHK(protectResetN, 1'b0)
		powerGood <= 1'b1;
		issue(OP_READ, a, 8'h00, 0, 1, {2'b10, ~(d + 8'h01)});
		while (pending.size() > 0) @(posedge clock);
		@(posedge clock);
		`CHK(busy, 1'b0)
		// supply drop from idle once the hold after the last byte has run out
		powerGood <= 1'b0;
		repeat (3) @(posedge clock);
		`CHK(protectResetN, 1'b0)
		`CHK(busy, 1'b1)
		final_report();
	end
endmodule : eew_host_ctrl_test
